/* File: core/sfsp_core.sv */
// Sensor output framing, standby sequencing and two-wire control target
//
// Overview of operation
// - Strobes and pixels change on one edge
// - Row strobe spans exactly the valid pixels
// - Frame strobe leads first row by 143
// - Frame strobe ends 23 after last row
// - Outputs defined while reset held, no clock
// - Reset never means low power
// - Standby waits for current frame end
// - Standby drives all video outputs low
// - Serial port deaf during standby
// - Control port is an I2C target
// - Start or stop accepted after final nack
// - Colour filter code readable at 0x6B
`timescale 1ns/1ns
`include "sfsp_map.svh"
module sfsp_core #(
    parameter logic [2:0] CFA_CODE = `SFSP_CFA_MONO,
    parameter logic [6:0] DEV_ADDR = `SFSP_DEV_ADDR // Arbitrary bus address
) (
    input wire logic clock_i, // Master clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic standby_i, // Standby request pin
    input wire logic serial_clock_i, // Serial clock pin
    input wire logic serial_data_line_i, // Serial data pin level
    output logic serial_data_line_o, // Serial data drive value
    output logic serial_data_line_oe_o, // Serial data pulled low
    input wire logic array_clock_i, // Pixel array readout clock
    input wire logic [9:0] array_pixel_i, // Pixel word from array
    input wire logic array_valid_i, // Pixel word offered
    output logic array_ready_o, // Pixel word accepted
    output logic pixel_clock_out_o, // Pixel clock to host
    output logic frame_window_strobe_o, // Frame valid
    output logic row_valid_strobe_o, // Line valid
    output logic [9:0] pixel_data_o // Pixel bus
);
    localparam sfsp_pkg::sfsp_core_s CORE_RST = '{
        fst: sfsp_pkg::FR_IDLE,
        ist: sfsp_pkg::I2_IDLE,
        ctrl: `SFSP_CTRL_RST, scl_sy: 2'h3, sda_sy: 2'h3, scl_d: 1'h1, sda_d: 1'h1, // Bus idles high
        default: '0
    };

    sfsp_pkg::sfsp_core_s s_r;
    sfsp_pkg::sfsp_core_s s_nxt;
    logic fifo_valid;
    logic [9:0] fifo_data;
    logic take;

    sfsp_fifo #(
        .WIDTH(`SFSP_PIX_W),
        .DEPTH(`SFSP_FIFO_DEPTH)
    ) u_fifo (
        .rst_n_i(rst_n_i),
        .wr_clk_i(array_clock_i),
        .wr_valid_i(array_valid_i),
        .wr_data_i(array_pixel_i),
        .wr_ready_o(array_ready_o),
        .rd_clk_i(clock_i),
        .rd_valid_o(fifo_valid),
        .rd_data_o(fifo_data),
        .rd_ready_i(take)
    );

    // Open drain: only ever pull low
    assign serial_data_line_o = 1'b0;
    assign serial_data_line_oe_o = s_r.oe;
    assign frame_window_strobe_o = s_r.fv;
    assign row_valid_strobe_o = s_r.lv;
    assign pixel_data_o = s_r.pix;
    // Inverted master clock, parked low in standby and under reset
    assign pixel_clock_out_o = s_r.clk_en & ~clock_i;

    always_comb
    begin
        logic [15:0] rword;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
        logic [7:0] next_byte;
        rword = 16'h0000;
        sda = s_r.sda_sy[1];
        scl_rise = s_r.scl_sy[1] & ~s_r.scl_d;
        scl_fall = ~s_r.scl_sy[1] & s_r.scl_d;
        start = s_r.scl_sy[1] & s_r.scl_d & s_r.sda_d & ~sda;
        stop = s_r.scl_sy[1] & s_r.scl_d & ~s_r.sda_d & sda;
        next_byte = 8'h00;
        s_nxt = s_r;
        take = 1'b0;

        s_nxt.stby_sy = {s_r.stby_sy[0], standby_i};
        s_nxt.scl_sy = {s_r.scl_sy[0], serial_clock_i};
        s_nxt.sda_sy = {s_r.sda_sy[0], serial_data_line_i};
        s_nxt.scl_d = s_r.scl_sy[1];
        s_nxt.sda_d = sda;

        // Serial port stays closed until ten edges after reset release
        if (!s_r.ready)
        begin
            s_nxt.wait_cnt = s_r.wait_cnt + 4'h1;
            if (s_r.wait_cnt == `SFSP_WAIT_EDGES - 4'h1)
                s_nxt.ready = 1'b1;
        end

        if (s_r.reg_a == `SFSP_REG_CFA_ID)
            rword = {4'h0, CFA_CODE, `SFSP_CFA_LOW};
        else if (s_r.reg_a == `SFSP_REG_CTRL)
            rword = s_r.ctrl;
        else if (s_r.reg_a == `SFSP_REG_STAT)
            rword = {13'h0000, s_r.fst == sfsp_pkg::FR_STBY, s_r.fv, s_r.under};

        case (s_r.fst)
            sfsp_pkg::FR_IDLE:
            begin
                // Reset lands here, never in standby
                if (s_r.stby_sy[1])
                    s_nxt.fst = sfsp_pkg::FR_STBY;
                else if (s_r.ready && !s_r.ctrl[`SFSP_CTRL_PAUSE])
                begin
                    s_nxt.fst = sfsp_pkg::FR_PRE;
                    s_nxt.fv = 1'b1;
                    s_nxt.cnt = 16'h0000;
                    s_nxt.row = 16'h0000;
                end
            end
            sfsp_pkg::FR_PRE:
            begin
                if (s_r.cnt == `SFSP_PRE_FV_CLKS - 16'h0001)
                begin
                    s_nxt.fst = sfsp_pkg::FR_ROW;
                    s_nxt.lv = 1'b1;
                    s_nxt.cnt = 16'h0000;
                    take = 1'b1;
                end
                else
                    s_nxt.cnt = s_r.cnt + 16'h0001;
            end
            sfsp_pkg::FR_ROW:
            begin
                if (s_r.cnt == `SFSP_ACTIVE_COLS - 16'h0001)
                begin
                    // Drops on the edge that ends the last pixel
                    s_nxt.lv = 1'b0;
                    s_nxt.pix = 10'h000;
                    s_nxt.cnt = 16'h0000;
                    if (s_r.row == `SFSP_ACTIVE_ROWS - 16'h0001)
                        s_nxt.fst = sfsp_pkg::FR_POST;
                    else
                    begin
                        s_nxt.fst = sfsp_pkg::FR_HBLK;
                        s_nxt.row = s_r.row + 16'h0001;
                    end
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt + 16'h0001;
                    take = 1'b1;
                end
            end
            sfsp_pkg::FR_HBLK:
            begin
                if (s_r.cnt == `SFSP_HBLANK_CLKS - 16'h0001)
                begin
                    s_nxt.fst = sfsp_pkg::FR_ROW;
                    s_nxt.lv = 1'b1;
                    s_nxt.cnt = 16'h0000;
                    take = 1'b1;
                end
                else
                    s_nxt.cnt = s_r.cnt + 16'h0001;
            end
            sfsp_pkg::FR_POST:
            begin
                if (s_r.cnt == `SFSP_POST_FV_CLKS - 16'h0001)
                begin
                    s_nxt.fst = sfsp_pkg::FR_VBLK;
                    s_nxt.fv = 1'b0;
                    s_nxt.cnt = 16'h0000;
                end
                else
                    s_nxt.cnt = s_r.cnt + 16'h0001;
            end
            sfsp_pkg::FR_VBLK:
            begin
                // Standby is honoured only here or in idle, so a frame always completes
                if (s_r.cnt == `SFSP_VBLANK_CLKS - 16'h0001)
                begin
                    s_nxt.fst = s_r.stby_sy[1] ? sfsp_pkg::FR_STBY : sfsp_pkg::FR_IDLE;
                    s_nxt.cnt = 16'h0000;
                end
                else
                    s_nxt.cnt = s_r.cnt + 16'h0001;
            end
            sfsp_pkg::FR_STBY:
            begin
                s_nxt.fv = 1'b0;
                s_nxt.lv = 1'b0;
                s_nxt.pix = 10'h000;
                if (!s_r.stby_sy[1])
                    s_nxt.fst = sfsp_pkg::FR_IDLE;
            end
            default:
            begin
                s_nxt.fst = sfsp_pkg::FR_IDLE;
            end
        endcase

        // An empty FIFO mid-row sends zero and flags the underrun
        if (take)
        begin
            s_nxt.pix = fifo_valid ? fifo_data : 10'h000;
            s_nxt.under = s_r.under | ~fifo_valid;
        end
        s_nxt.clk_en = (s_nxt.fst != sfsp_pkg::FR_STBY);

        if (start)
        begin
            s_nxt.oe = 1'b0;
            s_nxt.bits = 4'h0;
            if (s_r.ready && s_r.fst != sfsp_pkg::FR_STBY)
                s_nxt.ist = sfsp_pkg::I2_ADDR;
            else
                s_nxt.ist = sfsp_pkg::I2_IDLE;
        end
        else if (stop)
        begin
            s_nxt.ist = sfsp_pkg::I2_IDLE;
            s_nxt.oe = 1'b0;
        end
        else if (scl_rise)
        begin
            case (s_r.ist)
                sfsp_pkg::I2_ADDR, sfsp_pkg::I2_REG, sfsp_pkg::I2_WDAT:
                begin
                    s_nxt.sh = {s_r.sh[6:0], sda};
                    s_nxt.bits = s_r.bits + 4'h1;
                end
                sfsp_pkg::I2_RDAT:
                begin
                    s_nxt.bits = s_r.bits + 4'h1;
                end
                sfsp_pkg::I2_MACK:
                begin
                    s_nxt.ack = ~sda;
                end
                default:
                begin
                    s_nxt.bits = s_r.bits;
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (s_r.ist)
                sfsp_pkg::I2_ADDR:
                begin
                    if (s_r.bits == `SFSP_BYTE_BITS)
                    begin
                        s_nxt.bits = 4'h0;
                        s_nxt.rw = s_r.sh[0];
                        s_nxt.oe = (s_r.sh[7:1] == DEV_ADDR);
                        s_nxt.ist = (s_r.sh[7:1] == DEV_ADDR) ? sfsp_pkg::I2_AACK : sfsp_pkg::I2_IDLE;
                    end
                end
                sfsp_pkg::I2_AACK:
                begin
                    if (s_r.rw)
                    begin
                        s_nxt.ist = sfsp_pkg::I2_RDAT;
                        s_nxt.sh = rword[15:8];
                        s_nxt.oe = ~rword[15];
                        s_nxt.hi_sel = 1'b1;
                    end
                    else
                    begin
                        s_nxt.ist = sfsp_pkg::I2_REG;
                        s_nxt.oe = 1'b0;
                    end
                end
                sfsp_pkg::I2_REG:
                begin
                    if (s_r.bits == `SFSP_BYTE_BITS)
                    begin
                        s_nxt.reg_a = s_r.sh;
                        s_nxt.ist = sfsp_pkg::I2_RACK;
                        s_nxt.oe = 1'b1;
                        s_nxt.bits = 4'h0;
                        s_nxt.hi_sel = 1'b0;
                    end
                end
                sfsp_pkg::I2_RACK, sfsp_pkg::I2_WACK:
                begin
                    s_nxt.ist = sfsp_pkg::I2_WDAT;
                    s_nxt.oe = 1'b0;
                end
                sfsp_pkg::I2_WDAT:
                begin
                    if (s_r.bits == `SFSP_BYTE_BITS)
                    begin
                        s_nxt.ist = sfsp_pkg::I2_WACK;
                        s_nxt.oe = 1'b1;
                        s_nxt.bits = 4'h0;
                        s_nxt.hi_sel = ~s_r.hi_sel;
                        // Only the control word is writable; the rest ignore data
                        if (!s_r.hi_sel)
                            s_nxt.wr_hi = s_r.sh;
                        else if (s_r.reg_a == `SFSP_REG_CTRL)
                            s_nxt.ctrl = {s_r.wr_hi, s_r.sh};
                    end
                end
                sfsp_pkg::I2_RDAT:
                begin
                    if (s_r.bits == `SFSP_BYTE_BITS)
                    begin
                        s_nxt.ist = sfsp_pkg::I2_MACK;
                        s_nxt.oe = 1'b0;
                        s_nxt.bits = 4'h0;
                    end
                    else
                    begin
                        s_nxt.sh = {s_r.sh[6:0], 1'b0};
                        s_nxt.oe = ~s_r.sh[6];
                    end
                end
                sfsp_pkg::I2_MACK:
                begin
                    if (s_r.ack)
                    begin
                        next_byte = s_r.hi_sel ? rword[7:0] : rword[15:8];
                        s_nxt.ist = sfsp_pkg::I2_RDAT;
                        s_nxt.sh = next_byte;
                        s_nxt.oe = ~next_byte[7];
                        s_nxt.hi_sel = ~s_r.hi_sel;
                    end
                    else
                        s_nxt.ist = sfsp_pkg::I2_IDLE;
                end
                default:
                begin
                    s_nxt.oe = 1'b0;
                end
            endcase
        end

        if (s_r.fst == sfsp_pkg::FR_STBY)
        begin
            s_nxt.ist = sfsp_pkg::I2_IDLE;
            s_nxt.oe = 1'b0;
        end
    end

    // Async reset sets every output low with or without a running clock
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_r <= CORE_RST;
        else
            s_r <= s_nxt;
    end
endmodule

/* File: core/sfsp_fifo.sv */
// Dual-clock pixel FIFO with gray-coded pointers between array and master clocks
`timescale 1ns/1ns
module sfsp_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic rst_n_i, // Async reset, active low
    input wire logic wr_clk_i, // Array readout clock
    input wire logic wr_valid_i, // Word offered
    input wire logic [WIDTH-1:0] wr_data_i, // Word in
    output logic wr_ready_o, // Room for a word
    input wire logic rd_clk_i, // Master clock
    output logic rd_valid_o, // Word available
    output logic [WIDTH-1:0] rd_data_o, // Word out
    input wire logic rd_ready_i // Word taken
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [1:0] rst_sy;
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] s1;
        logic [AW:0] s2;
    } sfsp_wside_s;

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] s1;
        logic [AW:0] s2;
    } sfsp_rside_s;

    sfsp_wside_s w_r;
    sfsp_wside_s w_nxt;
    sfsp_rside_s r_r;
    sfsp_rside_s r_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic push;
    logic pop;

    // Write side stays closed until reset release has reached its own clock
    assign full = (w_r.gray == {~r_sy_top(w_r.s2), w_r.s2[AW-2:0]});
    assign wr_ready_o = w_r.rst_sy[1] & ~full;
    assign push = wr_valid_i & wr_ready_o;
    assign rd_valid_o = (r_r.gray != r_r.s2);
    assign pop = rd_valid_o & rd_ready_i;
    assign rd_data_o = mem[r_r.bin[AW-1:0]];

    function automatic logic [1:0] r_sy_top(input logic [AW:0] g);
        r_sy_top = g[AW:AW-1];
    endfunction

    always_comb
    begin
        w_nxt = w_r;
        w_nxt.rst_sy = {w_r.rst_sy[0], 1'b1};
        w_nxt.s1 = r_r.gray;
        w_nxt.s2 = w_r.s1;
        if (push)
        begin
            w_nxt.bin = w_r.bin + 1'b1;
        end
        w_nxt.gray = w_nxt.bin ^ (w_nxt.bin >> 1);
    end

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.s1 = w_r.gray;
        r_nxt.s2 = r_r.s1;
        if (pop)
        begin
            r_nxt.bin = r_r.bin + 1'b1;
        end
        r_nxt.gray = r_nxt.bin ^ (r_nxt.bin >> 1);
    end

    always_ff @(posedge wr_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            w_r <= '0;
        else
            w_r <= w_nxt;
    end

    always_ff @(posedge wr_clk_i)
    begin
        if (push)
            mem[w_r.bin[AW-1:0]] <= wr_data_i;
    end

    always_ff @(posedge rd_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            r_r <= '0;
        else
            r_r <= r_nxt;
    end
endmodule

/* File: core/sfsp_map.svh */
// Register offsets, field codes and timing counts of the sensor framing block
`ifndef SFSP_MAP_SVH
`define SFSP_MAP_SVH
`define SFSP_REG_CFA_ID 8'h6B
`define SFSP_REG_CTRL 8'hF0
`define SFSP_REG_STAT 8'hF1
`define SFSP_CTRL_RST 16'h0000
`define SFSP_CTRL_PAUSE 0
`define SFSP_CFA_RGB 3'h6
`define SFSP_CFA_RCCC 3'h5
`define SFSP_CFA_MONO 3'h0
`define SFSP_CFA_LOW 9'h004
`define SFSP_DEV_ADDR 7'h48
`define SFSP_WAIT_EDGES 4'hA
`define SFSP_PRE_FV_CLKS 16'h008F
`define SFSP_POST_FV_CLKS 16'h0017
`define SFSP_ACTIVE_COLS 16'h02F0
`define SFSP_ACTIVE_ROWS 16'h01E0
`define SFSP_HBLANK_CLKS 16'h005E
`define SFSP_VBLANK_CLKS 16'h03E8
`define SFSP_BYTE_BITS 4'h8
`define SFSP_FIFO_DEPTH 4
`define SFSP_PIX_W 10
`endif

/* File: core/sfsp_pkg.sv */
// Types shared by the sensor framing block: state encodings and state record
package sfsp_pkg;

    typedef enum logic [6:0] {
        FR_IDLE = 7'h01,
        FR_PRE = 7'h02,
        FR_ROW = 7'h04,
        FR_HBLK = 7'h08,
        FR_POST = 7'h10,
        FR_VBLK = 7'h20,
        FR_STBY = 7'h40
    } sfsp_frame_e;

    typedef enum logic [8:0] {
        I2_IDLE = 9'h001,
        I2_ADDR = 9'h002,
        I2_AACK = 9'h004,
        I2_REG = 9'h008,
        I2_RACK = 9'h010,
        I2_WDAT = 9'h020,
        I2_WACK = 9'h040,
        I2_RDAT = 9'h080,
        I2_MACK = 9'h100
    } sfsp_i2c_e;

    typedef struct packed {
        sfsp_frame_e fst;
        logic [15:0] cnt;
        logic [15:0] row;
        logic fv;
        logic lv;
        logic [9:0] pix;
        logic under;
        logic clk_en;
        logic [3:0] wait_cnt;
        logic ready;
        logic [1:0] stby_sy;
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic scl_d;
        logic sda_d;
        sfsp_i2c_e ist;
        logic [3:0] bits;
        logic [7:0] sh;
        logic rw;
        logic [7:0] reg_a;
        logic hi_sel;
        logic [7:0] wr_hi;
        logic ack;
        logic oe;
        logic [15:0] ctrl;
    } sfsp_core_s;

endpackage

/* File: tb/sfsp_core_sva.sv */
// Port-level assertions of the sensor framing block
`timescale 1ns/1ns
module sfsp_core_sva (
    input wire logic clock_i, // Master clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic standby_i, // Standby pin
    input wire logic serial_clock_i, // SCL pin
    input wire logic serial_data_line_o, // SDA value
    input wire logic serial_data_line_oe_o, // SDA pull
    input wire logic frame_window_strobe_o, // Frame valid
    input wire logic row_valid_strobe_o, // Line valid
    input wire logic [9:0] pixel_data_o // Pixel bus
);
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    logic [9:0] run_r;
    logic [3:0] age_r;
    sequence s_lead;
        ##142 !row_valid_strobe_o ##1 row_valid_strobe_o;
    endsequence
    // Last row has no successor, so frame strobe falling also ends the gap
    sequence s_gap;
        ##93 !row_valid_strobe_o ##1 (row_valid_strobe_o || !frame_window_strobe_o);
    endsequence
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            run_r <= 10'h000;
            age_r <= 4'h0;
        end
        else
        begin
            run_r <= row_valid_strobe_o ? run_r + 10'h001 : 10'h000;
            age_r <= (age_r == 4'hF) ? age_r : age_r + 4'h1;
        end
    end
    chk_fv_lead: assert property ($rose(frame_window_strobe_o) |-> s_lead)
        else $error("frame strobe lead wrong");
    chk_fv_tail: assert property ($fell(frame_window_strobe_o) |->
        $past(row_valid_strobe_o, 24) && !$past(row_valid_strobe_o, 23))
        else $error("frame strobe tail wrong");
    chk_row_len: assert property ($fell(row_valid_strobe_o) |-> run_r == 10'h2F0)
        else $error("row length wrong");
    chk_row_gap: assert property ($fell(row_valid_strobe_o) |-> s_gap)
        else $error("row gap wrong");
    chk_lv_in_fv: assert property (row_valid_strobe_o |-> frame_window_strobe_o)
        else $error("row strobe outside frame");
    chk_pix_idle: assert property (!row_valid_strobe_o |-> pixel_data_o == 10'h000)
        else $error("pixel bus busy outside row");
    chk_early_quiet: assert property (age_r < 4'hA |-> !frame_window_strobe_o && !serial_data_line_oe_o)
        else $error("activity before post-reset wait");
    chk_ack_scl: assert property ($changed(serial_data_line_oe_o) |->
        !serial_clock_i && !$past(serial_clock_i))
        else $error("data pull changed with serial clock high");
    chk_sda_low: assert property (serial_data_line_o == 1'b0)
        else $error("serial data drive value not low");
    chk_stby_hold: assert property (standby_i && $past(standby_i) && $past(standby_i, 2)
        && $past(standby_i, 3) |-> !$rose(frame_window_strobe_o))
        else $error("frame started during standby");
endmodule

/* File: tb/sfsp_core_test.sv */
// Bench of the sensor framing block: host model, pixel source, frame monitor
`timescale 1ns/1ns
`include "sfsp_map.svh"
module sfsp_core_test;
    logic clock_i = 1'b0;
    logic rst_n_i;
    logic standby_i = 1'b1;
    logic array_clock_i = 1'b0;
    logic av = 1'b0;
    logic [9:0] ad = 10'h000;
    logic tk = 1'b0;
    logic quiet = 1'b0;
    logic ok;
    logic [15:0] rd;
    logic [15:0] wv;
    logic [9:0] q[$];
    logic scl, pull, oe, so, ready, pclk, fv, lv;
    logic [9:0] pix;
    wire sda = !(pull || (oe && !so));
    int num_errors = 0;
    int checks_done = 0;
    int seed = 32'h22c0_39cd;
    int run = 0;
    int n;
    logic [7:0] offs [5] = '{8'h6A, `SFSP_REG_CFA_ID, 8'h6C, `SFSP_REG_CTRL, `SFSP_REG_STAT};
    sfsp_core #(
        .CFA_CODE(`SFSP_CFA_RGB),
        .DEV_ADDR(`SFSP_DEV_ADDR)
    ) sfsp_core_i (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .standby_i(standby_i),
        .serial_clock_i(scl),
        .serial_data_line_i(sda),
        .serial_data_line_o(so),
        .serial_data_line_oe_o(oe),
        .array_clock_i(array_clock_i),
        .array_pixel_i(ad),
        .array_valid_i(av),
        .array_ready_o(ready),
        .pixel_clock_out_o(pclk),
        .frame_window_strobe_o(fv),
        .row_valid_strobe_o(lv),
        .pixel_data_o(pix)
    );
    sfsp_host #(.DEV_ADDR(`SFSP_DEV_ADDR)) sfsp_host_i (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge clock_i);
        #1;
    endtask
    function automatic logic [15:0] exp_reg(input logic [7:0] ra);
        if (ra == `SFSP_REG_CTRL)
            return wv;
        if (ra == `SFSP_REG_STAT)
            return 16'h0002;
        return (ra == `SFSP_REG_CFA_ID) ? {4'h0, `SFSP_CFA_RGB, `SFSP_CFA_LOW} : 16'h0000;
    endfunction
    initial
    begin
        forever #50 clock_i = ~clock_i;
    end
    initial
    begin
        #3;
        forever #6 array_clock_i = ~array_clock_i;
    end
    initial
    begin
        wt(40000);
        num_errors++;
        $display("watchdog expired");
        close_out();
    end
    // Ready is read mid-cycle: it only moves on array clock edges
    initial
    begin
        forever
        begin
            @(negedge array_clock_i);
            tk = av && ready;
            @(posedge array_clock_i);
            if (tk && rst_n_i)
                q.push_back(ad);
            #1;
            if (tk || !av)
            begin
                av = |2'($random(seed)); // Three in four offered, so the FIFO keeps up
                ad = 10'($random(seed));
            end
        end
    end
    always @(negedge clock_i)
    begin
        if (lv === 1'b1)
        begin
            chk("pixel", pix, q.pop_front());
            run++;
        end
        else
        begin
            if (run != 0 && rst_n_i)
                chk("row length", run, `SFSP_ACTIVE_COLS);
            run = 0;
        end
        if (quiet)
            chk("standby outputs", {pclk, fv, lv, pix}, 32'h0000_0000);
    end
    initial
    begin
        #1;
        rst_n_i = 1'b0;
        #9;
        chk("reset outputs", {oe, ready, pclk, fv, lv, pix}, 32'h0000_0000);
        wt(16);
        rst_n_i = 1'b1;
        // Pixel clock runs until standby passes the pin synchroniser
        wt(4);
        quiet = 1'b1;
        sfsp_host_i.read16(`SFSP_REG_CFA_ID, 1'b1, rd, ok);
        chk("standby ack", ok, 1'b0);
        quiet = 1'b0;
        $display("standby test done");
        standby_i = 1'b0;
        n = 0;
        while (fv !== 1'b1 && n < 50)
        begin
            @(negedge clock_i);
            n++;
        end
        chk("frame start", fv, 1'b1);
        n = 0;
        while (lv !== 1'b1 && n < 300)
        begin
            @(negedge clock_i);
            n++;
        end
        chk("frame lead", n, `SFSP_PRE_FV_CLKS);
        $display("frame test done");
        wv = 16'($random(seed));
        sfsp_host_i.write16(`SFSP_REG_CTRL, wv, ok);
        chk("write ack", ok, 1'b1);
        foreach (offs[i])
        begin
            sfsp_host_i.read16(offs[i], i == 4, rd, ok);
            chk("target ack", ok, 1'b1);
            chk("register word", rd, exp_reg(offs[i]));
        end
        $display("serial test done");
        standby_i = 1'b1;
        wt(3000);
        chk("frame held", fv, 1'b1);
        rst_n_i = 1'b0;
        standby_i = 1'b0;
        q.delete();
        wt(16);
        rst_n_i = 1'b1;
        sfsp_host_i.start(2);
        sfsp_host_i.send8({`SFSP_DEV_ADDR, 1'b0}, ok);
        sfsp_host_i.stop();
        chk("early ack", ok, 1'b0);
        chk("frame after reset", fv, 1'b1);
        sfsp_host_i.read16(`SFSP_REG_CFA_ID, 1'b1, rd, ok);
        chk("late ack", ok, 1'b1);
        chk("late word", rd, exp_reg(`SFSP_REG_CFA_ID));
        $display("restart test done");
        close_out();
    end
endmodule
bind sfsp_core sfsp_core_sva sfsp_core_sva_i (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .standby_i(standby_i),
    .serial_clock_i(serial_clock_i),
    .serial_data_line_o(serial_data_line_o),
    .serial_data_line_oe_o(serial_data_line_oe_o),
    .frame_window_strobe_o(frame_window_strobe_o),
    .row_valid_strobe_o(row_valid_strobe_o),
    .pixel_data_o(pixel_data_o)
);

/* File: tb/sfsp_host.sv */
// Host model: two-wire control master of the sensor framing block
`timescale 1ns/1ns
module sfsp_host #(
    parameter logic [6:0] DEV_ADDR = 7'h48 // Must match the target
) (
    input wire logic clock_i, // Master clock, paces bits
    input wire logic sda_i, // Resolved data level
    output logic scl_o, // Serial clock
    output logic sda_pull_o // High pulls data low
);
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Data moves 5 cycles after the clock falls, so the synced clock never sees it race
    task automatic bitx(input logic b, output logic r);
        wt(5);
        sda_pull_o = !b;
        wt(15);
        scl_o = 1'b1;
        wt(20);
        r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic start(input int w);
        sda_pull_o = 1'b0;
        wt(w);
        scl_o = 1'b1;
        wt(w);
        sda_pull_o = 1'b1;
        wt(20);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        wt(5);
        sda_pull_o = 1'b1;
        wt(15);
        scl_o = 1'b1;
        wt(20);
        sda_pull_o = 1'b0;
        wt(20);
    endtask
    task automatic send8(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask
    task automatic get8(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(1'b1, d[i]);
        bitx(nack, r);
    endtask
    task automatic read16(input logic [7:0] ra, input logic fin, output logic [15:0] d, output logic ok);
        logic a0, a1, a2;
        start(7);
        send8({DEV_ADDR, 1'b0}, a0);
        send8(ra, a1);
        start(7);
        send8({DEV_ADDR, 1'b1}, a2);
        get8(1'b0, d[15:8]);
        get8(1'b1, d[7:0]);
        if (fin)
            stop();
        ok = a0 && a1 && a2;
    endtask
    task automatic write16(input logic [7:0] ra, input logic [15:0] wd, output logic ok);
        logic a0, a1, a2, a3;
        start(7);
        send8({DEV_ADDR, 1'b0}, a0);
        send8(ra, a1);
        send8(wd[15:8], a2);
        send8(wd[7:0], a3);
        stop();
        ok = a0 && a1 && a2 && a3;
    endtask
endmodule
